// [ptm_bridge.sv]
`timescale 1ns/1ps
module ptm_bridge
   import ptm_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [31:0] ad_in,
   output logic [31:0]      ad_out,
   output logic             ad_oe_out,
   input  wire logic [3:0]  cbe_n_in,
   output logic [3:0]       cbe_n_out,
   output logic             cbe_n_oe_out,
   input  wire logic        frame_n_in,
   output logic             frame_n_out,
   output logic             frame_n_oe_out,
   input  wire logic        irdy_n_in,
   output logic             irdy_n_out,
   output logic             irdy_n_oe_out,
   input  wire logic        trdy_n_in,
   output logic             trdy_n_out,
   output logic             trdy_n_oe_out,
   input  wire logic        stop_n_in,
   output logic             stop_n_out,
   output logic             stop_n_oe_out,
   input  wire logic        devsel_n_in,
   output logic             devsel_n_out,
   output logic             devsel_n_oe_out,
   output logic             par_out,
   output logic             par_oe_out,
   input  wire logic        par_in,
   output logic             serr_n_out,
   output logic             serr_n_oe_out,
   input  wire logic        pos_hit_in,
   input  wire logic [1:0]  sub_sample_sel_in,
   input  wire logic        tgt_ready_in,
   input  wire logic        tgt_retry_in,
   input  wire logic        tgt_disc_in,
   input  wire logic [31:0] tgt_rdata_in,
   output logic [31:0]      tgt_addr_out,
   output logic [3:0]       tgt_cmd_out,
   output logic             tgt_sub_out,
   output logic             tgt_start_out,
   output logic             tgt_xfer_out,
   output logic [31:0]      tgt_wdata_out,
   output logic [3:0]       tgt_be_out,
   input  wire logic        mst_req_in,
   input  wire logic [31:0] mst_addr_in,
   input  wire logic [3:0]  mst_cmd_in,
   input  wire logic [31:0] mst_wdata_in,
   input  wire logic [3:0]  mst_be_in,
   output logic             mst_busy_out,
   output logic             mst_done_out,
   output logic [1:0]       mst_status_out,
   output logic [31:0]      mst_rdata_out
);

   typedef struct packed {
      ptm_sl_state_t sl;
      ptm_m_state_t  m;
      logic [2:0]    cnt;
      logic [2:0]    mcnt;
      logic          sub;
      logic          rd;
      logic [31:0]   addr;
      logic [3:0]    cmd;
      logic          fprev;
      logic          devsel_n;
      logic          trdy_n;
      logic          stop_n;
      logic          t_oe;
      logic [31:0]   ad;
      logic          ad_oe;
      logic [3:0]    cbe;
      logic          cbe_oe;
      logic          frame_n;
      logic          frame_oe;
      logic          irdy_n;
      logic          irdy_oe;
      logic          par_oe;
      logic          apar;
      logic          achk;
      logic          serr;
      logic [31:0]   wdata;
      logic [3:0]    be;
      logic          xfer;
      logic          start;
      logic          done;
      logic [1:0]    mstat;
      logic [31:0]   rdata;
   } ptm_state_t;

   ptm_state_t q;
   ptm_state_t d;
   logic       par_load;
   logic       addr_start;
   logic       sl_done;
   logic [2:0] sub_clk;

   // Field 11 is unused and falls back to the slowest sample point.
   function automatic logic [2:0] sub_sample_clk(input logic [1:0] sel);
      case (sel)
         SUB_SEL_MED:  sub_sample_clk = 3'(SUB_DEVSEL_CLKS - 1);
         SUB_SEL_FAST: sub_sample_clk = 3'(SUB_DEVSEL_CLKS - 2);
         default:      sub_sample_clk = 3'(SUB_DEVSEL_CLKS);
      endcase
   endfunction

   function automatic logic sub_cmd_ok(input logic [3:0] cmd);
      sub_cmd_ok = (cmd == CMD_IO_RD) || (cmd == CMD_IO_WR) ||
                   (cmd == CMD_MEM_RD) || (cmd == CMD_MEM_WR);
   endfunction

   assign sub_clk    = sub_sample_clk(sub_sample_sel_in);
   assign addr_start = q.fprev && !frame_n_in;
   assign sl_done    = !q.trdy_n && !irdy_n_in;

   always_comb
   begin
      d          = q;
      par_load   = 1'b0;
      d.fprev    = frame_n_in;
      d.xfer     = 1'b0;
      d.start    = 1'b0;
      d.done     = 1'b0;
      d.serr     = 1'b0;
      d.achk     = addr_start;
      d.apar     = ptm_even_par(ad_in, cbe_n_in);
      if (q.achk && (par_in != q.apar))
      begin
         d.serr = 1'b1;
      end
      case (q.sl)
         PTM_SL_IDLE:
         begin
            if (addr_start && (q.m == PTM_M_IDLE))
            begin
               d.addr = ad_in;
               d.cmd  = cbe_n_in;
               d.rd   = !cbe_n_in[CMD_WR_BIT];
               d.cnt  = 3'(POS_DEVSEL_CLKS);
               if (pos_hit_in)
               begin
                  d.devsel_n = 1'b0;
                  d.t_oe     = 1'b1;
                  d.sub      = 1'b0;
                  d.start    = 1'b1;
                  d.sl       = PTM_SL_DATA;
               end
               else if (sub_cmd_ok(cbe_n_in))
               begin
                  d.sl = PTM_SL_WAIT;
               end
            end
         end
         PTM_SL_WAIT:
         begin
            d.cnt = q.cnt + 3'h1;
            if (!devsel_n_in || (frame_n_in && irdy_n_in))
            begin
               d.sl = PTM_SL_IDLE;
            end
            else if (q.cnt >= sub_clk - 3'h1)
            begin
               d.devsel_n = 1'b0;
               d.t_oe     = 1'b1;
               d.sub      = 1'b1;
               d.start    = 1'b1;
               d.sl       = PTM_SL_DATA;
            end
         end
         PTM_SL_DATA:
         begin
            d.ad_oe = q.rd;
            if (sl_done)
            begin
               d.xfer  = 1'b1;
               d.wdata = ad_in;
               d.be    = cbe_n_in;
               par_load = q.rd;
            end
            if (!q.trdy_n && irdy_n_in)
            begin
               d.trdy_n = 1'b0;
            end
            else
            begin
               d.trdy_n = 1'b1;
               if (frame_n_in && (irdy_n_in || sl_done))
               begin
                  d.devsel_n = 1'b1;
                  d.stop_n   = 1'b1;
                  d.ad_oe    = 1'b0;
                  d.sl       = PTM_SL_TURN;
               end
               else if (!q.stop_n)
               begin
                  d.stop_n = 1'b0;
               end
               else if (tgt_retry_in)
               begin
                  d.stop_n = 1'b0;
               end
               // disconnect
               // Frame is already high on the last data phase.
               else if (tgt_ready_in)
               begin
                  d.trdy_n = 1'b0;
                  d.ad     = tgt_rdata_in;
                  d.stop_n = !tgt_disc_in;
               end
            end
         end
         PTM_SL_TURN:
         begin
            d.t_oe = 1'b0;
            d.sl   = PTM_SL_IDLE;
         end
         default:
         begin
            d.sl = PTM_SL_IDLE;
         end
      endcase
      case (q.m)
         PTM_M_IDLE:
         begin
            if (mst_req_in && frame_n_in && irdy_n_in && q.fprev &&
                (q.sl == PTM_SL_IDLE))
            begin
               d.frame_n  = 1'b0;
               d.frame_oe = 1'b1;
               d.ad       = mst_addr_in;
               d.ad_oe    = 1'b1;
               d.cbe      = mst_cmd_in;
               d.cbe_oe   = 1'b1;
               d.rd       = !mst_cmd_in[CMD_WR_BIT];
               d.mcnt     = 3'h0;
               d.m        = PTM_M_ADDR;
            end
         end
         PTM_M_ADDR:
         begin
            par_load  = 1'b1;
            d.frame_n = 1'b1;
            d.irdy_n  = 1'b0;
            d.irdy_oe = 1'b1;
            d.cbe     = mst_be_in;
            d.ad      = mst_wdata_in;
            d.ad_oe   = !q.rd;
            d.m       = PTM_M_DATA;
         end
         PTM_M_DATA:
         begin
            d.mcnt = q.mcnt + 3'h1;
            if (!trdy_n_in)
            begin
               d.rdata  = ad_in;
               d.mstat  = stop_n_in ? PTM_ST_OK : PTM_ST_DISC;
               par_load = !q.rd;
               d.m      = PTM_M_TURN;
            end
            else if (!stop_n_in)
            begin
               d.mstat = devsel_n_in ? PTM_ST_ABORT : PTM_ST_RETRY;
               d.m     = PTM_M_TURN;
            end
            else if (devsel_n_in && (q.mcnt == 3'(MST_ABORT_CLKS - 1)))
            begin
               d.mstat = PTM_ST_ABORT;
               d.m     = PTM_M_TURN;
            end
            if (d.m == PTM_M_TURN)
            begin
               d.irdy_n   = 1'b1;
               d.ad_oe    = 1'b0;
               d.cbe_oe   = 1'b0;
               d.frame_oe = 1'b0;
               d.done     = 1'b1;
            end
         end
         PTM_M_TURN:
         begin
            d.irdy_oe = 1'b0;
            d.m       = PTM_M_IDLE;
         end
         default:
         begin
            d.m = PTM_M_IDLE;
         end
      endcase
      d.par_oe = par_load;
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         q          <= '0;
         q.fprev    <= PIN_IDLE_RST;
         q.devsel_n <= PIN_IDLE_RST;
         q.trdy_n   <= PIN_IDLE_RST;
         q.stop_n   <= PIN_IDLE_RST;
         q.frame_n  <= PIN_IDLE_RST;
         q.irdy_n   <= PIN_IDLE_RST;
         q.t_oe     <= OE_RST;
      end
      else
      begin
         q <= d;
      end
   end

   ptm_parity u_parity (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .ad_in    (ad_in),
      .cbe_n_in (cbe_n_in),
      .load_in  (par_load),
      .par_out  (par_out)
   );

   assign ad_out          = q.ad;
   assign ad_oe_out       = q.ad_oe;
   assign cbe_n_out       = q.cbe;
   assign cbe_n_oe_out    = q.cbe_oe;
   assign frame_n_out     = q.frame_n;
   assign frame_n_oe_out  = q.frame_oe;
   assign irdy_n_out      = q.irdy_n;
   assign irdy_n_oe_out   = q.irdy_oe;
   assign trdy_n_out      = q.trdy_n;
   assign trdy_n_oe_out   = q.t_oe;
   assign stop_n_out      = q.stop_n;
   assign stop_n_oe_out   = q.t_oe;
   assign devsel_n_out    = q.devsel_n;
   assign devsel_n_oe_out = q.t_oe;
   assign par_oe_out      = q.par_oe;
   assign serr_n_out      = 1'b0;
   assign serr_n_oe_out   = q.serr;
   assign tgt_addr_out    = q.addr;
   assign tgt_cmd_out     = q.cmd;
   assign tgt_sub_out     = q.sub;
   assign tgt_start_out   = q.start;
   assign tgt_xfer_out    = q.xfer;
   assign tgt_wdata_out   = q.wdata;
   assign tgt_be_out      = q.be;
   assign mst_busy_out    = (q.m != PTM_M_IDLE);
   assign mst_done_out    = q.done;
   assign mst_status_out  = q.mstat;
   assign mst_rdata_out   = q.rdata;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   property p_no_frame_slave;
      (q.sl != PTM_SL_IDLE) |-> !frame_n_oe_out;
   endproperty
   a_no_frame_slave: assert property (p_no_frame_slave)
      else $error("Frame driven while slave busy.");

   property p_irdy_hold;
      (q.sl == PTM_SL_DATA && !trdy_n_out && irdy_n_in)
         |=> !trdy_n_out && $stable(ad_out);
   endproperty
   a_irdy_hold: assert property (p_irdy_hold)
      else $error("Target ready dropped before initiator ready.");

   property p_read_data;
      (!trdy_n_out && q.rd && q.sl == PTM_SL_DATA) |-> ad_oe_out;
   endproperty
   a_read_data: assert property (p_read_data)
      else $error("Target ready on read without driving data.");

   property p_retry;
      (q.sl == PTM_SL_DATA && trdy_n_out && stop_n_out && tgt_retry_in &&
       !(frame_n_in && irdy_n_in)) |=> !stop_n_out && trdy_n_out;
   endproperty
   a_retry: assert property (p_retry)
      else $error("Retry not signalled as stop without ready.");

   property p_pos_claim;
      (q.sl == PTM_SL_IDLE && q.m == PTM_M_IDLE && addr_start && pos_hit_in)
         |=> !devsel_n_out && devsel_n_oe_out;
   endproperty
   a_pos_claim: assert property (p_pos_claim)
      else $error("Positive decode select not one clock after frame.");

   property p_sub_claim;
      (q.sl == PTM_SL_IDLE && q.m == PTM_M_IDLE && addr_start &&
       !pos_hit_in && sub_cmd_ok(cbe_n_in) && sub_sample_sel_in == 2'h0)
         ##1 (devsel_n_in && !(frame_n_in && irdy_n_in) &&
              $stable(sub_sample_sel_in))[*3]
         |=> !devsel_n_out;
   endproperty
   a_sub_claim: assert property (p_sub_claim)
      else $error("Subtractive select not four clocks after frame.");

   property p_foreign;
      (q.sl == PTM_SL_WAIT && !devsel_n_in) |=> !devsel_n_oe_out;
   endproperty
   a_foreign: assert property (p_foreign)
      else $error("Claimed a cycle another slave took.");

   property p_mst_par;
      (q.m == PTM_M_ADDR)
         |=> par_oe_out && (par_out == ^$past({ad_in, cbe_n_in}));
   endproperty
   a_mst_par: assert property (p_mst_par)
      else $error("Address parity not driven one clock later.");

   property p_sl_par;
      (q.sl == PTM_SL_DATA && q.rd && sl_done) |=> par_oe_out;
   endproperty
   a_sl_par: assert property (p_sl_par)
      else $error("Read parity not driven after completed phase.");

   property p_serr;
      (q.achk && par_in != q.apar) |=> serr_n_oe_out ##1 !serr_n_oe_out;
   endproperty
   a_serr: assert property (p_serr)
      else $error("Address parity error not pulsed.");

   property p_mst_stop;
      (q.m == PTM_M_DATA && !stop_n_in && trdy_n_in)
         |=> mst_done_out && !frame_n_oe_out ##1 !irdy_n_oe_out;
   endproperty
   a_mst_stop: assert property (p_mst_stop)
      else $error("Master did not end on target stop.");

   c_pos_read: cover property
      (q.sl == PTM_SL_DATA && q.rd && sl_done && !q.sub);
   c_sub_write: cover property
      (q.sl == PTM_SL_DATA && !q.rd && sl_done && q.sub);
   c_retry: cover property (!stop_n_out && trdy_n_out && stop_n_oe_out);
   c_mst_ok: cover property (mst_done_out && mst_status_out == PTM_ST_OK);

endmodule

// [ptm_pkg.sv]
package ptm_pkg;

   // Device-select timing, in PCI clocks after the address phase.
   localparam int unsigned POS_DEVSEL_CLKS = 1;
   localparam int unsigned SUB_DEVSEL_CLKS = 4;
   // Master abort: clocks of data phase waited for any device-select.
   localparam int unsigned MST_ABORT_CLKS  = 5;

   // Reset values of driven pins and their enables.
   localparam logic        PIN_IDLE_RST = 1'b1;
   localparam logic        OE_RST       = 1'b0;

   // Commands that may be claimed by subtractive decode.
   localparam logic [3:0] CMD_IO_RD  = 4'h2;
   localparam logic [3:0] CMD_IO_WR  = 4'h3;
   localparam logic [3:0] CMD_MEM_RD = 4'h6;
   localparam logic [3:0] CMD_MEM_WR = 4'h7;
   // Bit of the command that marks a write.
   localparam int unsigned CMD_WR_BIT = 0;

   // Values of the two-bit subtractive sample field.
   localparam logic [1:0] SUB_SEL_SLOW = 2'h0;
   localparam logic [1:0] SUB_SEL_MED  = 2'h1;
   localparam logic [1:0] SUB_SEL_FAST = 2'h2;

   typedef enum logic [1:0] {
      PTM_ST_OK    = 2'h0,
      PTM_ST_RETRY = 2'h1,
      PTM_ST_DISC  = 2'h2,
      PTM_ST_ABORT = 2'h3
   } ptm_status_t;

   typedef enum logic [1:0] {
      PTM_SL_IDLE = 2'h0,
      PTM_SL_WAIT = 2'h1,
      PTM_SL_DATA = 2'h2,
      PTM_SL_TURN = 2'h3
   } ptm_sl_state_t;

   typedef enum logic [1:0] {
      PTM_M_IDLE = 2'h0,
      PTM_M_ADDR = 2'h1,
      PTM_M_DATA = 2'h2,
      PTM_M_TURN = 2'h3
   } ptm_m_state_t;

   // Even parity bit over the address/data and command/byte-enable lines.
   function automatic logic ptm_even_par(input logic [31:0] ad,
                                         input logic [3:0]  cbe);
      ptm_even_par = ^{ad, cbe};
   endfunction

endpackage

// [ptm_parity.sv]
`timescale 1ns/1ps
module ptm_parity
   import ptm_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [31:0] ad_in,
   input  wire logic [3:0]  cbe_n_in,
   input  wire logic        load_in,
   output logic             par_out
);

   typedef struct packed {
      logic par;
   } ptm_par_state_t;

   ptm_par_state_t q;
   ptm_par_state_t d;

   always_comb
   begin
      d = q;
      if (load_in)
      begin
         d.par = ptm_even_par(ad_in, cbe_n_in);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign par_out = q.par;

endmodule

// [ptm_bus_partner.sv]
`timescale 1ns/1ps
module ptm_bus_partner
   import ptm_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic [31:0] ad_in,
   input  wire logic [3:0]  cbe_n_in,
   input  wire logic        frame_n_in,
   input  wire logic        irdy_n_in,
   input  wire logic        trdy_n_in,
   input  wire logic        stop_n_in,
   output logic [31:0]      ad_out,
   output logic             ad_oe_out,
   output logic [3:0]       cbe_n_out,
   output logic             frame_n_out,
   output logic             irdy_n_out,
   output logic             mst_oe_out,
   output logic             trdy_n_out,
   output logic             stop_n_out,
   output logic             devsel_n_out,
   output logic             tgt_oe_out,
   output logic             par_out,
   output logic             par_oe_out
);
   initial
   begin
      {ad_oe_out, mst_oe_out, tgt_oe_out, par_oe_out} = 4'h0;
      {frame_n_out, irdy_n_out, trdy_n_out, stop_n_out} = 4'hf;
      {devsel_n_out, ad_out, cbe_n_out, par_out} = {1'b1, 37'h0};
   end

   // One single-phase cycle as initiator; fdev adds a foreign fast target.
   task automatic master(input logic [31:0] a, input logic [3:0] c, be,
                         input logic [31:0] wd, input int iw,
                         input bit bad, fdev, output logic [31:0] rd,
                         output bit trd, stp);
      int k;
      k = 0;
      @(negedge clk_in);
      {frame_n_out, irdy_n_out, mst_oe_out, cbe_n_out} = {3'b011, c};
      {ad_out, ad_oe_out} = {a, 1'b1};
      @(negedge clk_in);
      {par_out, par_oe_out, cbe_n_out} = {^{a, c} ^ bad, 1'b1, be};
      ad_oe_out = c[CMD_WR_BIT];
      {devsel_n_out, trdy_n_out, tgt_oe_out} = {2'b00, fdev};
      repeat (40)
      begin
         // data valid only with ready; frame rises on last phase
         {frame_n_out, irdy_n_out} = (k >= iw) ? 2'b10 : 2'b01;
         ad_out = (k >= iw) ? wd : ~wd;
         @(posedge clk_in);
         // phase ends on initiator ready together with target ready or a stop
         if (!irdy_n_in && !(trdy_n_in && stop_n_in))
            break;
         @(negedge clk_in);
         par_oe_out = 1'b0;
         k++;
      end
      {rd, trd, stp} = {ad_in, !trdy_n_in, !stop_n_in};
      @(negedge clk_in);
      {par_out, par_oe_out} = {^{wd, be}, c[CMD_WR_BIT]};
      {frame_n_out, irdy_n_out, trdy_n_out, devsel_n_out} = 4'hf;
      ad_oe_out = 1'b0;
      @(negedge clk_in);
      {par_oe_out, mst_oe_out, tgt_oe_out} = 3'b000;
   endtask

   // Target answer: mode 0 ready, 1 retry, 2 disconnect, 3 no claim.
   task automatic target(input int mode, wt, input logic [31:0] rd,
                         output logic [31:0] a, wd,
                         output logic [3:0] c, be);
      repeat (10)
      begin
         @(posedge clk_in);
         if (!frame_n_in)
            break;
      end
      {a, c} = {ad_in, cbe_n_in};
      if (mode == 3)
         return;
      @(negedge clk_in);
      {devsel_n_out, trdy_n_out, stop_n_out, tgt_oe_out} = 4'b0111;
      repeat (wt + 1) @(negedge clk_in);
      {trdy_n_out, stop_n_out} = {mode == 1, mode == 0};
      {ad_out, ad_oe_out} = {rd, !c[CMD_WR_BIT]};
      repeat (20)
      begin
         @(posedge clk_in);
         if (!irdy_n_in)
            break;
      end
      {wd, be} = {ad_in, cbe_n_in};
      @(negedge clk_in);
      {devsel_n_out, trdy_n_out, stop_n_out, ad_oe_out} = 4'b1110;
      {par_out, par_oe_out} = {^{rd, be}, !c[CMD_WR_BIT] && mode != 1};
      @(negedge clk_in);
      {tgt_oe_out, par_oe_out} = 2'b00;
   endtask
endmodule

// [ptm_bridge_test.sv]
`timescale 1ns/1ps
module ptm_bridge_test;
   import ptm_pkg::*;
   logic        clk_in, rst_n_in, pos_hit_in, mst_req_in, flip, par_in;
   logic        tgt_ready_in, tgt_retry_in, tgt_disc_in, p_par, p_par_oe;
   logic [1:0]  sub_sample_sel_in, mst_status_out;
   logic [3:0]  cbe_n_in, cbe_n_out, mst_cmd_in, mst_be_in, tgt_cmd_out;
   logic [3:0]  tgt_be_out, p_cbe, cbe_p;
   logic [31:0] ad_in, ad_out, tgt_rdata_in, mst_addr_in, mst_wdata_in;
   logic [31:0] tgt_addr_out, tgt_wdata_out, mst_rdata_out, p_ad, ad_p;
   logic [31:0] seed;
   logic        frame_n_in, irdy_n_in, trdy_n_in, stop_n_in, devsel_n_in;
   logic        ad_oe_out, cbe_n_oe_out, frame_n_out, frame_n_oe_out;
   logic        irdy_n_out, irdy_n_oe_out, trdy_n_out, trdy_n_oe_out;
   logic        stop_n_out, stop_n_oe_out, devsel_n_out, devsel_n_oe_out;
   logic        par_out, par_oe_out, serr_n_out, serr_n_oe_out, tgt_sub_out;
   logic        tgt_start_out, tgt_xfer_out, mst_busy_out, mst_done_out;
   logic        p_ad_oe, p_frame, p_irdy, p_moe, p_trdy, p_stop, p_dev, p_toe;
   int          errors = 0, cmp_count = 0, cyc = 0, fcyc = 0, lat = -1;
   int          starts = 0, serrs = 0;
   bit          prev_f = 1'b1, in_mst = 1'b0;
   logic [36:0] exp_q[$], e;
   logic [3:0]  cmds[4] = '{CMD_IO_RD, CMD_IO_WR, CMD_MEM_RD, CMD_MEM_WR};

   // Undriven lines rest at the pull-up; AD, C/BE and PAR toggle instead, so a
   // stale value is never taken for a driven one.
   assign ad_in = ad_oe_out ? ad_out : p_ad_oe ? p_ad : {32{flip}};
   assign cbe_n_in = cbe_n_oe_out ? cbe_n_out : p_moe ? p_cbe : {4{flip}};
   assign frame_n_in = frame_n_oe_out ? frame_n_out : !p_moe | p_frame;
   assign irdy_n_in = irdy_n_oe_out ? irdy_n_out : !p_moe | p_irdy;
   assign trdy_n_in = trdy_n_oe_out ? trdy_n_out : !p_toe | p_trdy;
   assign stop_n_in = stop_n_oe_out ? stop_n_out : !p_toe | p_stop;
   assign devsel_n_in = devsel_n_oe_out ? devsel_n_out : !p_toe | p_dev;
   assign par_in = par_oe_out ? par_out : p_par_oe ? p_par : flip;

   ptm_bridge i_ptm_bridge (
      .clk_in, .rst_n_in, .ad_in, .ad_out, .ad_oe_out, .cbe_n_in,
      .cbe_n_out, .cbe_n_oe_out, .frame_n_in, .frame_n_out, .frame_n_oe_out,
      .irdy_n_in, .irdy_n_out, .irdy_n_oe_out, .trdy_n_in, .trdy_n_out,
      .trdy_n_oe_out, .stop_n_in, .stop_n_out, .stop_n_oe_out, .devsel_n_in,
      .devsel_n_out, .devsel_n_oe_out, .par_out, .par_oe_out, .par_in,
      .serr_n_out, .serr_n_oe_out, .pos_hit_in, .sub_sample_sel_in,
      .tgt_ready_in, .tgt_retry_in, .tgt_disc_in, .tgt_rdata_in,
      .tgt_addr_out, .tgt_cmd_out, .tgt_sub_out, .tgt_start_out,
      .tgt_xfer_out, .tgt_wdata_out, .tgt_be_out, .mst_req_in, .mst_addr_in,
      .mst_cmd_in, .mst_wdata_in, .mst_be_in, .mst_busy_out, .mst_done_out,
      .mst_status_out, .mst_rdata_out);

   ptm_bus_partner i_ptm_bus_partner (
      .clk_in, .ad_in, .cbe_n_in, .frame_n_in, .irdy_n_in, .trdy_n_in,
      .stop_n_in, .ad_out(p_ad), .ad_oe_out(p_ad_oe), .cbe_n_out(p_cbe),
      .frame_n_out(p_frame), .irdy_n_out(p_irdy), .mst_oe_out(p_moe),
      .trdy_n_out(p_trdy), .stop_n_out(p_stop), .devsel_n_out(p_dev),
      .tgt_oe_out(p_toe), .par_out(p_par), .par_oe_out(p_par_oe));

   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   always @(negedge clk_in)
      flip <= ~flip;

   task automatic chk(input string n, input logic [31:0] s, x);
      cmp_count++;
      if (s !== x)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, x, s);
      end
   endtask

   task automatic results;
      $display("comparisons %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc > 5000)
      begin
         errors++;
         results();
      end
      if (frame_n_in === 1'b0 && prev_f)
         fcyc = cyc;
      if (devsel_n_oe_out === 1'b1 && devsel_n_out === 1'b0 && lat < 0)
         lat = cyc - fcyc;
      serrs += (serr_n_oe_out === 1'b1 && serr_n_out === 1'b0);
      starts += (tgt_start_out === 1'b1);
      // Parity covers the lines of the previous clock.
      if (par_oe_out === 1'b1)
         chk("par", par_out, ^{ad_p, cbe_p});
      if (!in_mst)
         chk("frame_oe", frame_n_oe_out, 1'b0);
      if (tgt_xfer_out === 1'b1)
      begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
         chk("be", tgt_be_out, e[35:32]);
         if (e[36])
            chk("wdata", tgt_wdata_out, e[31:0]);
      end
      {prev_f, ad_p, cbe_p} = {frame_n_in, ad_in, cbe_n_in};
   end

   task automatic slv(input bit pos, input logic [1:0] sel,
                      input logic [3:0] cmd, input int iw, xl,
                      input bit fdev, bad, rty, dsc);
      logic [31:0] a, wd, rd, dat;
      logic [3:0]  be;
      bit          trd, stp;
      int          s0, e0;
      {a, wd, dat, be} = {rnd(), rnd(), rnd(), 4'(rnd())};
      @(negedge clk_in);
      {pos_hit_in, sub_sample_sel_in, tgt_retry_in, tgt_disc_in} =
         {pos, sel, rty, dsc};
      {tgt_ready_in, tgt_rdata_in, s0, e0} = {!rty, dat, starts, serrs};
      lat = -1;
      if (!fdev && !rty)
         exp_q.push_back({cmd[CMD_WR_BIT], be, wd});
      i_ptm_bus_partner.master(a, cmd, be, wd, iw, bad, fdev, rd, trd, stp);
      repeat (3) @(negedge clk_in);
      {tgt_retry_in, tgt_disc_in} = 2'b00;
      chk("devsel_lat", lat, xl);
      chk("start", starts - s0, !fdev);
      chk("serr", serrs - e0, bad);
      chk("pending", exp_q.size(), 0);
      if (fdev)
         return;
      chk("stop_trdy", {stp, trd}, {rty | dsc, !rty});
      chk("sub", {tgt_sub_out, tgt_cmd_out}, {!pos, cmd});
      chk("addr", tgt_addr_out, a);
      if (!rty && !cmd[CMD_WR_BIT])
         chk("rdata", rd, dat);
   endtask

   task automatic mop(input logic [3:0] cmd, input ptm_status_t st,
                      input int wt);
      logic [31:0] a, wd, rd, ga, gw;
      logic [3:0]  be, gc, gb;
      {a, wd, rd, be} = {rnd(), rnd(), rnd(), 4'(rnd())};
      @(negedge clk_in);
      {mst_req_in, mst_addr_in, mst_cmd_in, mst_wdata_in, mst_be_in} =
         {1'b1, a, cmd, wd, be};
      in_mst = 1'b1;
      fork
         i_ptm_bus_partner.target(int'(st), wt, rd, ga, gw, gc, gb);
         begin
            for (int i = 0; i < 4 && mst_busy_out !== 1'b1; i++)
               @(negedge clk_in);
            mst_req_in = 1'b0;
            for (int i = 0; i < 20 && mst_done_out !== 1'b1; i++)
               @(negedge clk_in);
         end
      join
      chk("status", mst_status_out, st);
      chk("maddr", ga, a);
      chk("mcmd", gc, cmd);
      if (st != PTM_ST_ABORT)
         chk("mbe", gb, be);
      if (st != PTM_ST_ABORT && cmd[CMD_WR_BIT])
         chk("mwdata", gw, wd);
      if ((st == PTM_ST_OK || st == PTM_ST_DISC) && !cmd[CMD_WR_BIT])
         chk("mrdata", mst_rdata_out, rd);
      repeat (3) @(negedge clk_in);
      in_mst = 1'b0;
   endtask

   initial
   begin
      {seed, rst_n_in, pos_hit_in, mst_req_in, flip} = {32'h57, 4'b0000};
      {tgt_ready_in, tgt_retry_in, tgt_disc_in, sub_sample_sel_in} = 5'h0;
      {tgt_rdata_in, mst_addr_in, mst_cmd_in, mst_wdata_in} = 'h0;
      mst_be_in = 4'h0;
      repeat (16) @(negedge clk_in);
      rst_n_in = 1'b1;
      repeat (3) @(negedge clk_in);
      slv(1, 2'h0, CMD_MEM_RD, 0, 1, 0, 0, 0, 0);
      slv(1, 2'h0, CMD_IO_WR, 3, 1, 0, 1, 0, 0);
      for (int s = 0; s < 4; s++)
         slv(0, s[1:0], cmds[s], 0, (s == 3) ? 4 : 4 - s, 0, 0, 0, 0);
      slv(0, 2'h0, CMD_IO_RD, 0, -1, 1, 0, 0, 0);
      slv(1, 2'h0, CMD_MEM_RD, 0, 1, 0, 0, 1, 0);
      slv(1, 2'h0, CMD_MEM_WR, 1, 1, 0, 0, 0, 1);
      for (int i = 0; i < 8; i++)
         mop(i[0] ? CMD_MEM_WR : CMD_IO_RD, ptm_status_t'(i >> 1), i % 3);
      results();
   end
endmodule
